// File: logic/protection_limits_defs.svh
// Function
// - After_fault_a clear: stay off after fault
// - After_fault_a set: restart, keep register contents
// - Register reset loads reset flag one
// - Decode thermal prewarn threshold field
`ifndef PROTECTION_LIMITS_DEFS_SVH
`define PROTECTION_LIMITS_DEFS_SVH

// ---------------------------------------------
// Register map
// ---------------------------------------------
`define PLC_ADDR 8'h16
`define PLC_RESET 8'h02
`define PLC_BIT_AFTER_FAULT_A 0
`define PLC_BIT_RSTFLAG 1
`define PLC_BIT_FORCE 2
`define PLC_BIT_SPARE 3
`define PLC_TPW_LSB 4
`define PLC_IPK_LSB 6
`define PLC_RESTART_HOLD 8'h10

`endif

// File: logic/protection_limits_pkg.sv
package protection_limits_pkg;
  typedef enum logic [1:0] {
    TEMP_83C,
    TEMP_94C,
    TEMP_105C,
    TEMP_116C
  } prewarn_temp_t;
  typedef enum logic [1:0] {
    PEAK_5A2,
    PEAK_5A8,
    PEAK_6A2,
    PEAK_6A8
  } peak_limit_t;
  typedef enum {
    ST_RUN,
    ST_LATCHED_OFF,
    ST_RESTART
  } fault_state_t;
endpackage

// File: logic/fault_after_fault_a_if.sv
`timescale 1ns/1ps
interface fault_after_fault_a_if;
  logic fault;
  logic after_fault_a;
  logic power_enable;
  logic restart;
  modport ctrl (input fault, input after_fault_a, output power_enable, output restart);
  modport host (output fault, output after_fault_a, input power_enable, input restart);
endinterface

// File: logic/fault_after_fault_a_ctrl.sv
`timescale 1ns/1ps
`include "protection_limits_defs.svh"
module fault_after_fault_a_ctrl (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Sync reset
  fault_after_fault_a_if.ctrl fr // Fault link
);
  protection_limits_pkg::fault_state_t state;
  logic [7:0] hold;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= protection_limits_pkg::ST_RUN;
      hold <= 8'h00;
    end else begin
      unique case (state)
        protection_limits_pkg::ST_RUN: begin
          if (fr.fault) begin
            state <= fr.after_fault_a ? protection_limits_pkg::ST_RESTART
                              : protection_limits_pkg::ST_LATCHED_OFF;
            hold <= 8'h00;
          end
        end
        // Stays off until a full reset
        protection_limits_pkg::ST_LATCHED_OFF: state <= state;
        protection_limits_pkg::ST_RESTART: begin
          // Wait for fault to clear, then a short hold before power-up
          if (fr.fault) hold <= 8'h00;
          else if (hold == `PLC_RESTART_HOLD) state <= protection_limits_pkg::ST_RUN;
          else hold <= hold + 8'h01;
        end
      endcase
    end
  end
  assign fr.power_enable = (state == protection_limits_pkg::ST_RUN) && !fr.fault;
  assign fr.restart = (state == protection_limits_pkg::ST_RESTART) && !fr.fault
                      && (hold == `PLC_RESTART_HOLD);
endmodule

// File: logic/protection_limits_config.sv
`timescale 1ns/1ps
`include "protection_limits_defs.svh"
module protection_limits_config (
  input wire logic sys_clk_in, // 200 MHz clock
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic [7:0] reg_addr_in, // Register address
  input wire logic reg_wr_in, // Write strobe
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic reg_rd_in, // Read strobe
  output logic [7:0] reg_rdata_out, // Read data
  output logic reg_hit_out, // Address matches
  input wire logic thermal_shutdown_fault_in, // Async fault pin
  input wire logic output_short_fault_in, // Async fault pin
  output logic power_enable_out, // Converter allowed on
  output logic power_up_start_out, // Restart pulse
  output logic register_default_out, // Pulse: all registers to default
  output logic [1:0] thermal_prewarn_threshold_out, // Raw field
  output protection_limits_pkg::prewarn_temp_t prewarn_temp_out, // Decoded threshold
  output logic [1:0] inductor_peak_limit_out, // Raw field
  output protection_limits_pkg::peak_limit_t peak_limit_out // Decoded limit
);
  // ---------------------------------------------
  // Field helpers
  // ---------------------------------------------
  // One extractor keeps raw and decoded views on the same bits
  function automatic logic [1:0] field2(input logic [7:0] value, input int unsigned lsb);
    logic [1:0] result;
    result = value[lsb +: 2];
    return result;
  endfunction

  function automatic protection_limits_pkg::prewarn_temp_t decode_temp(input logic [1:0] code);
    protection_limits_pkg::prewarn_temp_t temp;
    temp = protection_limits_pkg::TEMP_83C;
    case (code)
      2'b00: begin
        temp = protection_limits_pkg::TEMP_83C;
      end
      2'b01: begin
        temp = protection_limits_pkg::TEMP_94C;
      end
      2'b10: begin
        temp = protection_limits_pkg::TEMP_105C;
      end
      2'b11: begin
        temp = protection_limits_pkg::TEMP_116C;
      end
    endcase
    return temp;
  endfunction

  function automatic protection_limits_pkg::peak_limit_t decode_peak(input logic [1:0] code);
    protection_limits_pkg::peak_limit_t limit;
    limit = protection_limits_pkg::PEAK_5A2;
    case (code)
      2'b00: begin
        limit = protection_limits_pkg::PEAK_5A2;
      end
      2'b01: begin
        limit = protection_limits_pkg::PEAK_5A8;
      end
      2'b10: begin
        limit = protection_limits_pkg::PEAK_6A2;
      end
      2'b11: begin
        limit = protection_limits_pkg::PEAK_6A8;
      end
    endcase
    return limit;
  endfunction

  // Force and spare bits are never stored: force is a strobe, spare reads zero
  function automatic logic [7:0] shape_write(input logic [7:0] data);
    logic [7:0] shaped;
    shaped = 8'h00;
    shaped[`PLC_BIT_AFTER_FAULT_A] = data[`PLC_BIT_AFTER_FAULT_A];
    shaped[`PLC_BIT_RSTFLAG] = data[`PLC_BIT_RSTFLAG];
    shaped[`PLC_TPW_LSB +: 2] = field2(data, `PLC_TPW_LSB);
    shaped[`PLC_IPK_LSB +: 2] = field2(data, `PLC_IPK_LSB);
    return shaped;
  endfunction

  // ---------------------------------------------
  // Fault synchronisers
  // ---------------------------------------------
  // Pins are asynchronous; only the second stage feeds logic
  logic [1:0] tsd_sync;
  logic [1:0] short_sync;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tsd_sync <= 2'b00;
    end else begin
      tsd_sync <= {tsd_sync[0], thermal_shutdown_fault_in};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      short_sync <= 2'b00;
    end else begin
      short_sync <= {short_sync[0], output_short_fault_in};
    end
  end

  wire tsd_seen = tsd_sync[1];
  wire short_seen = short_sync[1];
  wire any_fault = tsd_seen || short_seen;

  // ---------------------------------------------
  // Access decode
  // ---------------------------------------------
  wire hit = (reg_addr_in == `PLC_ADDR);
  wire wr_hit = reg_wr_in && hit;
  wire rd_hit = reg_rd_in && hit;
  wire force_req = wr_hit && reg_wdata_in[`PLC_BIT_FORCE];
  // A force write ignores the other bits of the same byte
  wire plain_wr = wr_hit && !reg_wdata_in[`PLC_BIT_FORCE];
  wire [7:0] wr_val = shape_write(reg_wdata_in);

  // ---------------------------------------------
  // Register
  // ---------------------------------------------
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic force_pulse;

  always_comb begin
    next_cfg = cfg;
    if (force_req) begin
      next_cfg = `PLC_RESET;
    end else if (plain_wr) begin
      // Host clears the flag by writing zero
      next_cfg = wr_val;
    end
  end

  // Reset value carries the flag, so software can see every restore
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cfg <= `PLC_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Pulse also resets the after_fault_a control, so force is a full restore
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      force_pulse <= 1'b0;
    end else begin
      force_pulse <= force_req;
    end
  end

  // After_fault_a restart never touches cfg, so programmed values survive
  wire after_fault_a_bit = cfg[`PLC_BIT_AFTER_FAULT_A];

  // ---------------------------------------------
  // Fault after_fault_a control
  // ---------------------------------------------
  // Latched-off is left only by a reset or a force write
  fault_after_fault_a_if fr_link();
  wire after_fault_a_rst_n = rst_n_in && !force_pulse;

  assign fr_link.fault = any_fault;
  assign fr_link.after_fault_a = after_fault_a_bit;

  fault_after_fault_a_ctrl u_after_fault_a (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(after_fault_a_rst_n),
    .fr(fr_link)
  );

  wire power_allowed = fr_link.power_enable;
  wire restart_pulse = fr_link.restart;

  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  // Other addresses read zero; the value holds until the next read strobe
  logic [7:0] rdata;
  wire [7:0] next_rdata = rd_hit ? cfg : 8'h00;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata <= 8'h00;
    end else if (reg_rd_in) begin
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------
  // Field views
  // ---------------------------------------------
  logic [1:0] tpw_code;
  logic [1:0] ipk_code;
  protection_limits_pkg::prewarn_temp_t tpw_temp;
  protection_limits_pkg::peak_limit_t ipk_limit;

  assign tpw_code = field2(cfg, `PLC_TPW_LSB);
  assign ipk_code = field2(cfg, `PLC_IPK_LSB);
  assign tpw_temp = decode_temp(tpw_code);
  assign ipk_limit = decode_peak(ipk_code);

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign reg_rdata_out = rdata;
  assign reg_hit_out = hit;

  assign power_enable_out = power_allowed;
  assign power_up_start_out = restart_pulse;
  assign register_default_out = force_pulse;

  assign thermal_prewarn_threshold_out = tpw_code;
  assign prewarn_temp_out = tpw_temp;
  assign inductor_peak_limit_out = ipk_code;
  assign peak_limit_out = ipk_limit;
endmodule

// File: sim/protection_limits_config_checker.sv
`timescale 1ns/1ps
`include "protection_limits_defs.svh"
module protection_limits_checker (
  input wire logic sys_clk_in, // Clk
  input wire logic rst_n_in, // Rst
  input wire logic [7:0] reg_addr_in, // Addr
  input wire logic reg_wr_in, // Wr
  input wire logic [7:0] reg_wdata_in, // Data
  input wire logic reg_rd_in, // Rd
  input wire logic [7:0] reg_rdata_out, // Rdata
  input wire logic thermal_shutdown_fault_in, // Fault
  input wire logic output_short_fault_in, // Fault
  input wire logic power_enable_out, // On
  input wire logic power_up_start_out, // Restart
  input wire logic register_default_out, // Force
  input wire logic [1:0] thermal_prewarn_threshold_out, // Raw
  input protection_limits_pkg::prewarn_temp_t prewarn_temp_out, // Dec
  input wire logic [1:0] inductor_peak_limit_out, // Raw
  input protection_limits_pkg::peak_limit_t peak_limit_out // Dec
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_temp;
    reg_wr_in && reg_addr_in == `PLC_ADDR && !reg_wdata_in[`PLC_BIT_FORCE] |=>
      {2'b00, thermal_prewarn_threshold_out, 4'h0} == ($past(reg_wdata_in) & 8'h30)
      && {2'b00, prewarn_temp_out, 4'h0} == ($past(reg_wdata_in) & 8'h30);
  endproperty
  a_temp: assert property (p_temp) else $error("prewarn decode");
  property p_peak;
    reg_wr_in && reg_addr_in == `PLC_ADDR && !reg_wdata_in[`PLC_BIT_FORCE] |=>
      {inductor_peak_limit_out, 6'h00} == ($past(reg_wdata_in) & 8'hc0)
      && {peak_limit_out, 6'h00} == ($past(reg_wdata_in) & 8'hc0);
  endproperty
  a_peak: assert property (p_peak) else $error("peak decode");
  property p_force; reg_wr_in && reg_addr_in == 8'h16 && reg_wdata_in[2] |=> register_default_out;
  endproperty
  a_force: assert property (p_force) else $error("no default pulse");
  property p_flag; register_default_out && reg_rd_in && reg_addr_in == 8'h16 |=> reg_rdata_out == 8'h02;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_off; thermal_shutdown_fault_in [*3] |-> !power_enable_out; endproperty
  a_off: assert property (p_off) else $error("power on in fault");
  property p_rst; power_up_start_out |-> !$past(output_short_fault_in, 16)
    && !$past(thermal_shutdown_fault_in, 16) ##1 !power_up_start_out;
  endproperty
  a_rst: assert property (p_rst) else $error("bad restart");
endmodule
bind protection_limits_config protection_limits_checker i_protection_limits_checker (.sys_clk_in,
  .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out,
  .thermal_shutdown_fault_in, .output_short_fault_in, .power_enable_out, .power_up_start_out,
  .register_default_out, .thermal_prewarn_threshold_out, .prewarn_temp_out,
  .inductor_peak_limit_out, .peak_limit_out);

// File: sim/tb_protection_limits_config.sv
`timescale 1ns/1ps
module tb_protection_limits_config;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, thermal_shutdown_fault = 0, sht = 0, pe, pus, def, hit;
  logic [7:0] addr = 8'h16, wd = 8'h00, rdat;
  logic [1:0] tth, ipk;
  protection_limits_pkg::prewarn_temp_t tt;
  protection_limits_pkg::peak_limit_t pk;
  int err_count = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  protection_limits_config i_protection_limits_config (.sys_clk_in(clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .reg_hit_out(hit), .thermal_shutdown_fault_in(thermal_shutdown_fault),
    .output_short_fault_in(sht), .power_enable_out(pe), .power_up_start_out(pus),
    .register_default_out(def), .thermal_prewarn_threshold_out(tth), .prewarn_temp_out(tt),
    .inductor_peak_limit_out(ipk), .peak_limit_out(pk));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Leading wait keeps two writes from toggling the strobe in one step
  task automatic wr8(input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd8(input logic [7:0] e);
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("cfg", e, rdat);
  endtask
  task automatic t_reset_flag;
    rd8(8'h02);
    wr8(8'h00);
    rd8(8'h00);
  endtask
  task automatic t_fields;
    protection_limits_pkg::prewarn_temp_t temps [4];
    protection_limits_pkg::peak_limit_t peaks [4];
    temps = '{protection_limits_pkg::TEMP_83C, protection_limits_pkg::TEMP_94C,
      protection_limits_pkg::TEMP_105C, protection_limits_pkg::TEMP_116C};
    peaks = '{protection_limits_pkg::PEAK_5A2, protection_limits_pkg::PEAK_5A8,
      protection_limits_pkg::PEAK_6A2, protection_limits_pkg::PEAK_6A8};
    for (int i = 0; i < 4; i++) begin
      logic [1:0] hi;
      logic [1:0] lo;
      hi = i[1:0];
      lo = ~hi;
      wr8({hi, lo, 4'h0});
      rd8({hi, lo, 4'h0});
      chk("temp", {6'h00, temps[lo]}, {6'h00, tt});
      chk("peak", {6'h00, peaks[hi]}, {6'h00, pk});
      chk("temp_raw", {6'h00, lo}, {6'h00, tth});
      chk("peak_raw", {6'h00, hi}, {6'h00, ipk});
    end
  endtask
  task automatic t_refused;
    addr = 8'h17;
    wr8(8'h04);
    chk("default", 8'h00, {7'h00, def});
    chk("hit", 8'h00, {7'h00, hit});
    rd8(8'h00);
    addr = 8'h16;
    @(negedge clk);
    chk("hit", 8'h01, {7'h00, hit});
    rd8(8'h02);
    wr8(8'h0b);
    rd8(8'h03);
  endtask
  task automatic t_force;
    wr8(8'hf5);
    chk("default", 8'h01, {7'h00, def});
    rd8(8'h02);
  endtask
  task automatic t_latch;
    wr8(8'h00);
    thermal_shutdown_fault = 1;
    repeat (4) @(negedge clk);
    thermal_shutdown_fault = 0;
    repeat (30) @(negedge clk);
    chk("power", 8'h00, {7'h00, pe});
    wr8(8'h04);
    repeat (3) @(negedge clk);
    chk("power", 8'h01, {7'h00, pe});
  endtask
  task automatic t_after_fault_a;
    wr8(8'h01);
    sht = 1;
    repeat (4) @(negedge clk);
    chk("power", 8'h00, {7'h00, pe});
    sht = 0;
    for (int n = 0; n < 40 && pus !== 1'b1; n++) @(negedge clk);
    chk("restart", 8'h01, {7'h00, pus});
    repeat (2) @(negedge clk);
    chk("power", 8'h01, {7'h00, pe});
    rd8(8'h01);
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    t_reset_flag;
    t_fields;
    t_force;
    t_refused;
    t_latch;
    t_after_fault_a;
    close_out;
  end
endmodule
